// ---- pkg/csm_defines.svh ----
// Constants for the processor architectural state block
`ifndef CSM_DEFINES_SVH
`define CSM_DEFINES_SVH
`define CSM_OFS_PC 12'h000
`define CSM_OFS_PSW 12'h004
`define CSM_OFS_TBR 12'h008
`define CSM_OFS_RP 12'h00c
`define CSM_OFS_SSP 12'h010
`define CSM_OFS_USP 12'h014
`define CSM_OFS_MDH 12'h018
`define CSM_OFS_MDL 12'h01c
`define CSM_OFS_MODE 12'h020
`define CSM_OFS_STBY 12'h024
`define CSM_OFS_IRQ 12'h028
`define CSM_OFS_ALU 12'h02c
`define CSM_OFS_DIR 12'h030
`define CSM_OFS_GPR 12'h040
`define CSM_GPR_SEL 12'h080
`define CSM_PSW_MASK 32'h001f_033f
`define CSM_BIT_C 0
`define CSM_BIT_V 1
`define CSM_BIT_Z 2
`define CSM_BIT_N 3
`define CSM_BIT_I 4
`define CSM_BIT_S 5
`define CSM_BIT_T 8
`define CSM_ILM_LO 16
`define CSM_ILM_HI 20
`define CSM_ILM_RST 5'h0f
`define CSM_DIR_BYTE 32'h0000_00ff
`define CSM_DIR_HALF 32'h0000_01ff
`define CSM_DIR_WORD 32'h0000_03ff
`define CSM_SP_IDX 4'hf
`define CSM_OFS_R15 12'h07c
`define CSM_REG_RST 32'h0000_0000
`define CSM_ALU_A_HI 15
`define CSM_ALU_B_LO 16
`define CSM_ALU_B_HI 23
`define CSM_ALU_OP_LO 24
`define CSM_ALU_OP_HI 25
`define CSM_MD_EXT8 3'h0
`define CSM_MD_EXT16 3'h1
`define CSM_MD_INTVEC 3'h3
`define CSM_SZ_BYTE 2'h0
`define CSM_SZ_HALF 2'h1
`endif

// ---- pkg/csm_pkg.sv ----
// Types for the processor architectural state block
package csm_pkg;
	typedef enum logic [1:0] {CSM_ADD, CSM_SUB, CSM_LOGIC, CSM_NONE} csm_aluop_t;
	typedef enum logic [1:0] {CSM_EXT8, CSM_EXT16, CSM_PROHIB, CSM_INTVEC} csm_mode_t;
	typedef enum logic [1:0] {CSM_SB_ARMING, CSM_SB_READY, CSM_SB_ACTIVE} csm_sb_t;
endpackage

// ---- src/csm_flags.sv ----
// Condition flag computation for add, subtract and logic results
`include "csm_defines.svh"
module csm_flags
	import csm_pkg::*;
(
	input wire logic [31:0] op_a,
	input wire logic [31:0] op_b,
	input wire csm_aluop_t op,
	output logic [31:0] result,
	output logic [3:0] nzvc
);
	logic [32:0] sum;
	logic n, z, v, c;
	always_comb begin
		sum = 33'h0_0000_0000;
		v = 1'b0;
		c = 1'b0;
		case (op)
			CSM_ADD: begin
				sum = {1'b0, op_a} + {1'b0, op_b};
				c = sum[32];
				v = (op_a[31] == op_b[31]) && (sum[31] != op_a[31]);
			end
			CSM_SUB: begin
				sum = {1'b0, op_a} - {1'b0, op_b};
				c = sum[32];
				v = (op_a[31] != op_b[31]) && (sum[31] != op_a[31]);
			end
			CSM_LOGIC: begin
				sum = {1'b0, op_a & op_b};
			end
			default: begin
				sum = {1'b0, op_a};
			end
		endcase
		result = sum[31:0];
		n = sum[31];
		z = (sum[31:0] == 32'h0000_0000);
		nzvc = {n, z, v, c};
	end
endmodule

// ---- src/csm_regs.sv ----
// Architectural state registers with APB access
//
// Local design decisions: the APB register port and the address map.
`include "csm_defines.svh"
module csm_regs
	import csm_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic hardware_standby_input_n,
	input wire logic [2:0] mode_select_pins,
	input wire logic irq_req,
	input wire logic [4:0] irq_level,
	input wire logic irq_user,
	output logic irq_accept,
	output logic standby,
	output logic trace_enable,
	output logic [31:0] program_counter,
	output logic [31:0] vector_table_base,
	output logic [1:0] bus_mode,
	output logic mode_prohibited
);
	//////////////////////////////////////////////////////////////////
	// Bus decode
	logic wr_en;
	logic rd_en;
	logic [31:0] pc_q;
	logic [31:0] psw_q;
	logic [31:0] tbr_q;
	logic [31:0] rp_q;
	logic [31:0] ssp_q;
	logic [31:0] usp_q;
	logic [31:0] mdh_q;
	logic [31:0] mdl_q;
	logic [31:0] gpr_q [0:14];
	logic [31:0] prdata_q;
	logic [31:0] alu_a_q;
	logic [31:0] alu_b_q;
	csm_aluop_t alu_op_q;
	logic [2:0] mode_q;
	logic [31:0] dir_q;
	logic [2:0] hst_sync_q;
	logic [2:0] md_sync1_q;
	logic [2:0] md_sync2_q;
	logic irq_sync1_q;
	logic irq_sync2_q;
	logic irq_accept_q;
	logic [4:0] lvl_sync1_q;
	logic [4:0] lvl_sync2_q;
	logic usr_sync1_q;
	logic usr_sync2_q;
	logic alu_wr_q;
	csm_sb_t sb_q;
	logic [31:0] alu_res;
	logic [3:0] alu_nzvc;
	logic err;

	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && penable && !pwrite;
	assign pready = psel && penable;

	function automatic logic mapped(input logic [11:0] a);
		mapped = (a[1:0] == 2'b00) && (a <= `CSM_OFS_DIR ||
			(a >= `CSM_OFS_GPR && a < `CSM_GPR_SEL));
	endfunction

	// General register index from byte address
	function automatic logic [3:0] gidx(input logic [11:0] a);
		logic [11:0] d;
		d = a - `CSM_OFS_GPR;
		gidx = d[5:2];
	endfunction

	// Register fifteen follows the selected stack pointer
	function automatic logic [31:0] r15(input logic [31:0] psw, input logic [31:0] s,
		input logic [31:0] u);
		r15 = psw[`CSM_BIT_S] ? u : s;
	endfunction

	// Write strobe for one register offset
	function automatic logic wr_at(input logic w, input logic [11:0] a,
		input logic [11:0] ofs);
		wr_at = w && (a == ofs);
	endfunction

	// Aligned address inside the general register window
	function automatic logic is_gpr(input logic [11:0] a);
		is_gpr = (a[1:0] == 2'b00) && (a >= `CSM_OFS_GPR) && (a < `CSM_GPR_SEL);
	endfunction

	assign err = pready && !mapped(paddr);
	assign pslverr = err;

	//////////////////////////////////////////////////////////////////
	// Pin synchronisers
	always_ff @(posedge sys_clk) begin
		hst_sync_q <= {hst_sync_q[1:0], hardware_standby_input_n};
	end

	always_ff @(posedge sys_clk) begin
		md_sync1_q <= mode_select_pins;
		md_sync2_q <= md_sync1_q;
	end

	always_ff @(posedge sys_clk) begin
		irq_sync1_q <= irq_req;
		irq_sync2_q <= irq_sync1_q;
	end

	always_ff @(posedge sys_clk) begin
		lvl_sync1_q <= irq_level;
		lvl_sync2_q <= lvl_sync1_q;
	end

	always_ff @(posedge sys_clk) begin
		usr_sync1_q <= irq_user;
		usr_sync2_q <= usr_sync1_q;
	end

	// Mode pins latched while reset is held
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			mode_q <= md_sync2_q;
		end
	end

	always_comb begin
		case (mode_q)
			`CSM_MD_EXT8: bus_mode = CSM_EXT8;
			`CSM_MD_EXT16: bus_mode = CSM_EXT16;
			`CSM_MD_INTVEC: bus_mode = CSM_INTVEC;
			default: bus_mode = CSM_PROHIB;
		endcase
	end
	assign mode_prohibited = (bus_mode == CSM_PROHIB);

	//////////////////////////////////////////////////////////////////
	// Hardware standby: needs a high level after reset before a low counts
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sb_q <= CSM_SB_ARMING;
		end else begin
			case (sb_q)
				CSM_SB_ARMING: if (hst_sync_q[2]) sb_q <= CSM_SB_READY;
				CSM_SB_READY: if (!hst_sync_q[2]) sb_q <= CSM_SB_ACTIVE;
				CSM_SB_ACTIVE: if (hst_sync_q[2]) sb_q <= CSM_SB_READY;
				default: sb_q <= CSM_SB_ARMING;
			endcase
		end
	end
	assign standby = (sb_q == CSM_SB_ACTIVE);

	//////////////////////////////////////////////////////////////////
	// Flag computation
	csm_flags u_flags (
		.op_a(alu_a_q),
		.op_b(alu_b_q),
		.op(alu_op_q),
		.result(alu_res),
		.nzvc(alu_nzvc)
	);

	//////////////////////////////////////////////////////////////////
	// Program counter
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pc_q <= `CSM_REG_RST;
		end else if (wr_at(wr_en, paddr, `CSM_OFS_PC)) begin
			pc_q <= pwdata;
		end
	end

	// Vector table base
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			tbr_q <= `CSM_REG_RST;
		end else if (wr_at(wr_en, paddr, `CSM_OFS_TBR)) begin
			tbr_q <= pwdata;
		end
	end

	// Return pointer
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rp_q <= `CSM_REG_RST;
		end else if (wr_at(wr_en, paddr, `CSM_OFS_RP)) begin
			rp_q <= pwdata;
		end
	end

	// System stack pointer, also register fifteen while S is clear
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ssp_q <= `CSM_REG_RST;
		end else if (wr_at(wr_en, paddr, `CSM_OFS_SSP)) begin
			ssp_q <= pwdata;
		end else if (wr_at(wr_en, paddr, `CSM_OFS_R15) && !psw_q[`CSM_BIT_S]) begin
			ssp_q <= pwdata;
		end
	end

	// User stack pointer, also register fifteen while S is set
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			usp_q <= `CSM_REG_RST;
		end else if (wr_at(wr_en, paddr, `CSM_OFS_USP)) begin
			usp_q <= pwdata;
		end else if (wr_at(wr_en, paddr, `CSM_OFS_R15) && psw_q[`CSM_BIT_S]) begin
			usp_q <= pwdata;
		end
	end

	// Multiply/divide result, high part
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			mdh_q <= `CSM_REG_RST;
		end else if (wr_at(wr_en, paddr, `CSM_OFS_MDH)) begin
			mdh_q <= pwdata;
		end
	end

	// Multiply/divide result, low part
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			mdl_q <= `CSM_REG_RST;
		end else if (wr_at(wr_en, paddr, `CSM_OFS_MDL)) begin
			mdl_q <= pwdata;
		end
	end

	// Direct area access size
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			dir_q <= `CSM_REG_RST;
		end else if (wr_at(wr_en, paddr, `CSM_OFS_DIR)) begin
			dir_q <= pwdata;
		end
	end

	// General registers 0..14 keep no reset value; unaligned writes are refused
	always_ff @(posedge sys_clk) begin
		if (wr_en && is_gpr(paddr) && gidx(paddr) != `CSM_SP_IDX) begin
			gpr_q[gidx(paddr)] <= pwdata;
		end
	end

	// Operand registers; operands sit at the top so sign, carry and overflow are reachable
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			alu_a_q <= `CSM_REG_RST;
			alu_b_q <= `CSM_REG_RST;
			alu_op_q <= CSM_NONE;
		end else if (wr_at(wr_en, paddr, `CSM_OFS_ALU)) begin
			alu_a_q <= {pwdata[`CSM_ALU_A_HI:0], 16'h0000};
			alu_b_q <= {pwdata[`CSM_ALU_B_HI:`CSM_ALU_B_LO], 24'h00_0000};
			alu_op_q <= csm_aluop_t'(pwdata[`CSM_ALU_OP_HI:`CSM_ALU_OP_LO]);
		end
	end

	//////////////////////////////////////////////////////////////////
	// Status word; flag update from the unit after an operand write
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			psw_q <= {11'h000, `CSM_ILM_RST, 16'h0000};
			alu_wr_q <= 1'b0;
		end else begin
			alu_wr_q <= wr_at(wr_en, paddr, `CSM_OFS_ALU);
			if (wr_at(wr_en, paddr, `CSM_OFS_PSW)) begin
				psw_q <= pwdata & `CSM_PSW_MASK;
			end else if (alu_wr_q && alu_op_q != CSM_NONE) begin
				psw_q[`CSM_BIT_N:`CSM_BIT_C] <= alu_nzvc;
			end
		end
	end

	assign trace_enable = psw_q[`CSM_BIT_T];
	assign program_counter = pc_q;
	assign vector_table_base = tbr_q;

	//////////////////////////////////////////////////////////////////
	// Interrupt acceptance against the live mask
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			irq_accept_q <= 1'b0;
		end else begin
			irq_accept_q <= irq_sync2_q &&
				(lvl_sync2_q < psw_q[`CSM_ILM_HI:`CSM_ILM_LO]) &&
				(!usr_sync2_q || psw_q[`CSM_BIT_I]);
		end
	end
	assign irq_accept = irq_accept_q;

	//////////////////////////////////////////////////////////////////
	// Read data
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			prdata_q <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			case (paddr)
				`CSM_OFS_PC: prdata_q <= pc_q;
				`CSM_OFS_PSW: prdata_q <= psw_q;
				`CSM_OFS_TBR: prdata_q <= tbr_q;
				`CSM_OFS_RP: prdata_q <= rp_q;
				`CSM_OFS_SSP: prdata_q <= ssp_q;
				`CSM_OFS_USP: prdata_q <= usp_q;
				`CSM_OFS_MDH: prdata_q <= mdh_q;
				`CSM_OFS_MDL: prdata_q <= mdl_q;
				`CSM_OFS_MODE: prdata_q <= {29'h0, mode_q};
				`CSM_OFS_STBY: prdata_q <= {30'h0, sb_q};
				`CSM_OFS_IRQ: prdata_q <= {31'h0, irq_accept_q};
				`CSM_OFS_ALU: prdata_q <= alu_res;
				// Direct area limit for the access size in bits 1:0
				`CSM_OFS_DIR: prdata_q <= (dir_q[1:0] == `CSM_SZ_BYTE) ? `CSM_DIR_BYTE :
					(dir_q[1:0] == `CSM_SZ_HALF) ? `CSM_DIR_HALF : `CSM_DIR_WORD;
				default: begin
					if (is_gpr(paddr)) begin
						prdata_q <= (gidx(paddr) == `CSM_SP_IDX) ?
							r15(psw_q, ssp_q, usp_q) : gpr_q[gidx(paddr)];
					end else begin
						prdata_q <= 32'h0000_0000;
					end
				end
			endcase
		end
	end
	assign prdata = rd_en ? prdata_q : 32'h0000_0000;
endmodule

// ---- tb/csm_regs_sva.sv ----
// Port checker for the architectural state block
module csm_regs_sva (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic irq_accept,
	input wire logic trace_enable,
	input wire logic [1:0] bus_mode,
	input wire logic mode_prohibited
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	wire logic psw_wr = psel && penable && pwrite && paddr == 12'h004;
	property p_ready; psel && penable |-> pready; endproperty
	a_ready: assert property (p_ready) else $error("no ready in access");
	property p_err; psel && penable && paddr[1:0] != 2'h0 |-> pslverr; endproperty
	a_err: assert property (p_err) else $error("unaligned not refused");
	property p_erracc; pslverr |-> psel && penable; endproperty
	a_erracc: assert property (p_erracc) else $error("stray error");
	property p_mode; mode_prohibited == (bus_mode == 2'h2); endproperty
	a_mode: assert property (p_mode) else $error("prohibited flag wrong");
	property p_hold; !$past(rst) |-> $stable(bus_mode); endproperty
	a_hold: assert property (p_hold) else $error("bus mode moved");
	property p_ton; psw_wr && pwdata[8] |-> ##[1:2] trace_enable; endproperty
	a_ton: assert property (p_ton) else $error("trace not set");
	property p_toff; psw_wr && !pwdata[8] |-> ##[1:2] !trace_enable; endproperty
	a_toff: assert property (p_toff) else $error("trace not cleared");
	property p_ilm0; psw_wr && pwdata[20:16] == 5'h0 |-> ##3 !irq_accept; endproperty
	a_ilm0: assert property (p_ilm0) else $error("accept past mask 0");
endmodule
bind csm_regs csm_regs_sva u_sva (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr,
	.pwdata, .pready, .pslverr, .irq_accept, .trace_enable, .bus_mode, .mode_prohibited);

// ---- tb/csm_board.sv ----
// Board model: standby pin and mode straps
module csm_board (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic stby_req,
	input wire logic [2:0] strap,
	output logic hardware_standby_input_n,
	output logic [2:0] mode_select_pins
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] up_q = 3'h0;
	// Pin low from power-up, raised some cycles after reset ends
	always @(posedge sys_clk) begin
		if (!rst && up_q != 3'h7)
			up_q <= up_q + 3'h1;
	end
	assign hardware_standby_input_n = (up_q == 3'h7) ? !stby_req : 1'b0;
	assign mode_select_pins = strap;
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench for the architectural state block
module tb_top
	import csm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, er, irq_req, irq_user;
	logic hardware_standby_input_n, irq_accept, standby, trace_enable, mode_prohibited;
	logic stby_req;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, program_counter, vector_table_base;
	logic [4:0] irq_level;
	logic [2:0] strap, mode_select_pins;
	logic [1:0] bus_mode;
	int err_count, checked;
	logic [11:0] ofs [7] = '{12'h0, 12'h8, 12'hc, 12'h10, 12'h14, 12'h18, 12'h1c};
	logic [31:0] alu [7] = '{32'h0101_0000, 32'h0101_0100, 32'h020f_00f0, 32'h0002_0001,
		32'h0001_7fff, 32'h0080_8000, 32'h0101_8000};
	logic [3:0] nzvc [7] = '{4'h9, 4'h4, 4'h4, 4'h0, 4'ha, 4'h7, 4'h2};
	logic [31:0] ipsw [7] = '{32'hf_0000, 32'hf_0000, 32'hf_0000, 32'h1f_0000,
		32'h1f_0000, 32'h1f_0010, 32'h0};
	logic [5:0] ilv [7] = '{6'h05, 6'h0f, 6'h14, 6'h14, 6'h34, 6'h34, 6'h00};
	logic [6:0] iacc = 7'b0101001;
	csm_regs u_dut (
		.sys_clk(sys_clk),
		.rst(rst),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.hardware_standby_input_n(hardware_standby_input_n),
		.mode_select_pins(mode_select_pins),
		.irq_req(irq_req),
		.irq_level(irq_level),
		.irq_user(irq_user),
		.irq_accept(irq_accept),
		.standby(standby),
		.trace_enable(trace_enable),
		.program_counter(program_counter),
		.vector_table_base(vector_table_base),
		.bus_mode(bus_mode),
		.mode_prohibited(mode_prohibited)
	);
	csm_board u_brd (.sys_clk, .rst, .stby_req, .strap, .hardware_standby_input_n,
		.mode_select_pins);
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	task automatic final_report;
		$display("Mismatches %0d, comparisons %0d", err_count, checked);
		if (err_count == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			err_count++;
			$display("Error %0t: got %h exp %h", $time, g, e);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	task automatic reset_dut(input logic [2:0] m);
		strap <= m;
		rst <= 1'b1;
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
	endtask
	initial begin
		repeat (40000) @(posedge sys_clk);
		err_count++;
		final_report();
	end
	initial begin
		{rst, psel, penable, pwrite, paddr, pwdata} <= {1'b1, 47'h0};
		{irq_req, irq_level, irq_user, stby_req, strap} <= 11'h0;
		@(posedge sys_clk);
		for (int m = 0; m < 4; m++) begin
			reset_dut(m[2:0]);
			if (m == 0) chk(standby, 1'b0);
			strap <= m[2:0] ^ 3'h1;
			repeat (4) @(posedge sys_clk);
			chk(bus_mode, m);
			chk(mode_prohibited, m == 2);
		end
		chk(standby, 1'b0);
		stby_req <= 1'b1;
		repeat (8) @(posedge sys_clk);
		chk(standby, 1'b1);
		rdc(12'h024, 32'h2);
		stby_req <= 1'b0;
		repeat (8) @(posedge sys_clk);
		rdc(12'h004, 32'h000f_0000);
		rdc(12'h07c, 32'h0);
		foreach (ofs[i]) begin
			wr(ofs[i], 32'ha5a5_0000 + i);
			rdc(ofs[i], 32'ha5a5_0000 + i);
		end
		chk(program_counter, 32'ha5a5_0000);
		chk(vector_table_base, 32'ha5a5_0001);
		wr(12'h004, 32'h0);
		rdc(12'h07c, 32'ha5a5_0003);
		wr(12'h004, 32'h20);
		rdc(12'h07c, 32'ha5a5_0004);
		wr(12'h07c, 32'h1234_5678);
		rdc(12'h014, 32'h1234_5678);
		wr(12'h074, 32'hdead_beef);
		rdc(12'h074, 32'hdead_beef);
		wr(12'h076, 32'h0);
		chk(er, 1'b1);
		rdc(12'h042, 32'h0);
		rdc(12'h080, 32'h0);
		chk(er, 1'b1);
		rdc(12'h074, 32'hdead_beef);
		wr(12'h004, 32'hffff_ffff);
		rdc(12'h004, 32'h001f_033f);
		chk(trace_enable, 1'b1);
		wr(12'h004, 32'h0);
		chk(trace_enable, 1'b0);
		foreach (alu[i]) begin
			wr(12'h02c, alu[i]);
			repeat (2) @(posedge sys_clk);
			apb(1'b0, 12'h004, 32'h0);
			chk(rd[3:0], nzvc[i]);
		end
		rdc(12'h02c, 32'h7f00_0000);
		for (int s = 0; s < 3; s++) begin
			wr(12'h030, s);
			rdc(12'h030, (32'h100 << s) - 1);
		end
		foreach (ipsw[i]) begin
			wr(12'h004, ipsw[i]);
			irq_req <= 1'b1;
			irq_level <= ilv[i][4:0];
			irq_user <= ilv[i][5];
			repeat (6) @(posedge sys_clk);
			chk(irq_accept, iacc[i]);
		end
		irq_req <= 1'b0;
		rdc(12'h200, 32'h0);
		chk(er, 1'b1);
		wr(12'h006, 32'h1);
		chk(er, 1'b1);
		final_report();
	end
endmodule
